// *** pss_pkg.sv ***
/*
  Package for the program sequencer: widths, phase codes, op codes, register map.
  Assumes nothing of its surroundings; used by every design file of the sequencer.
*/
`default_nettype none
package pss_pkg;
  localparam int PC_W = 10;
  localparam int PAGE_W = 2;
  localparam int OFS_W = 8;
  localparam int DEPTH = 4;
  localparam int SP_W = 3;
  localparam logic [PC_W-1:0] RESET_VECTOR = 10'h000;
  localparam logic [PC_W-1:0] INT_VECTOR_DEF = 10'h004;
  localparam logic [1:0] REG_PC_LOW = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_INTVEC = 2'h2;
  localparam logic [SP_W-1:0] SP_EMPTY = 3'h0;

  typedef enum logic [1:0] {
    PH_T1 = 2'b00,
    PH_T2 = 2'b01,
    PH_T3 = 2'b10,
    PH_T4 = 2'b11
  } pss_phase_t;

  typedef enum logic [2:0] {
    OP_SEQ = 3'b000,
    OP_JUMP = 3'b001,
    OP_CALL = 3'b010,
    OP_RET = 3'b011,
    OP_RETURN_FROM_INTERRUPT = 3'b100,
    OP_SKIP = 3'b101
  } pss_op_t;

  // one decoded instruction as offered by the decoder at the end of an instruction cycle
  typedef struct packed {
    logic valid;
    pss_op_t op;
    logic [PC_W-1:0] target;
    logic skip_true;
  } pss_instr_t;

  typedef struct packed {
    logic push;
    logic pop;
    logic [PC_W-1:0] data;
  } pss_stack_req_t;
endpackage : pss_pkg
`default_nettype wire

// *** pss_phase_gen.sv ***
/*
  Four-phase generator: splits the system clock into a rotating phase code.
  Assumes a synchronous active-low reset copy from the top module.
*/
`timescale 1ns/10ps
`default_nettype none
module pss_phase_gen
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // phase
  output var pss_pkg::pss_phase_t phase,
  output logic cycle_end
);
  pss_pkg::pss_phase_t phase_q;

  // exactly one phase at a time, T1 to T4 then back to T1
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      phase_q <= pss_pkg::PH_T1;
    else
      case (phase_q)
        pss_pkg::PH_T1: phase_q <= pss_pkg::PH_T2;
        pss_pkg::PH_T2: phase_q <= pss_pkg::PH_T3;
        pss_pkg::PH_T3: phase_q <= pss_pkg::PH_T4;
        pss_pkg::PH_T4: phase_q <= pss_pkg::PH_T1;
        default: phase_q <= pss_pkg::PH_T1;
      endcase
  end

  assign phase = phase_q;
  assign cycle_end = (phase_q == pss_pkg::PH_T4);
endmodule : pss_phase_gen
`default_nettype wire

// *** pss_ret_stack.sv ***
/*
  Circular return-address stack of DEPTH entries with a hidden pointer.
  Assumes push and pop never come together and are single-cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module pss_ret_stack #(
  parameter int DEPTH = pss_pkg::DEPTH
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // requests
  input wire pss_pkg::pss_stack_req_t req,
  // state
  output logic [pss_pkg::PC_W-1:0] top,
  output logic full,
  output logic empty
);
  logic [pss_pkg::PC_W-1:0] mem_q [DEPTH];
  logic [1:0] wr_q;
  logic [pss_pkg::SP_W-1:0] cnt_q;

  // newest entry overwrites the oldest once full; pointer wraps
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q <= 2'h0;
      cnt_q <= pss_pkg::SP_EMPTY;
    end
    else if (req.push)
    begin
      wr_q <= wr_q + 2'h1;
      if (cnt_q != 3'(DEPTH))
        cnt_q <= cnt_q + 3'h1;
    end
    else if (req.pop)
    begin
      wr_q <= wr_q - 2'h1;
      if (cnt_q != pss_pkg::SP_EMPTY)
        cnt_q <= cnt_q - 3'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (req.push)
      mem_q[wr_q] <= req.data;
  end

  assign top = mem_q[wr_q - 2'h1];
  assign full = (cnt_q == 3'(DEPTH));
  assign empty = (cnt_q == pss_pkg::SP_EMPTY);
endmodule : pss_ret_stack
`default_nettype wire

// *** pss_sequencer.sv ***
/*
  Program sequencer: four-phase instruction cycle, overlapped fetch and execute,
  10-bit program counter with writable low byte, skip and branch dummy cycles,
  4-level return stack with interrupt hold-off while full.
  Assumes program memory answers fetch_addr with fetch_word within the cycle and
  a decoder presents instr during T4 of the cycle executing that word.
*/
`timescale 1ns/10ps
`default_nettype none
module pss_sequencer #(
  parameter logic [pss_pkg::PC_W-1:0] INT_VECTOR = pss_pkg::INT_VECTOR_DEF
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // program memory
  output logic [pss_pkg::PC_W-1:0] fetch_addr,
  output logic fetch_strobe,
  input wire logic [13:0] fetch_word,
  // decoder
  input wire pss_pkg::pss_instr_t instr,
  output logic [13:0] exec_word,
  output logic exec_valid,
  output logic [1:0] phase_out,
  // interrupt logic
  input wire logic int_req,
  output logic int_ack
);
  logic rst_s1_q;
  logic rst_n_q;
  pss_pkg::pss_phase_t phase;
  logic cycle_end;
  pss_pkg::pss_stack_req_t sreq;
  logic [pss_pkg::PC_W-1:0] stk_top;
  logic stk_full;
  logic stk_empty;
  logic [pss_pkg::PC_W-1:0] pc_q;
  logic [pss_pkg::PC_W-1:0] pc_d;
  logic [13:0] ir_q;
  logic ir_valid_q;
  logic flush_d;
  logic pcl_wr_pend_q;
  logic [7:0] pcl_new_q;
  logic int_pend_q;
  logic int_req_q;
  logic int_rise;
  logic int_take;
  logic [7:0] rdata_q;
  logic [pss_pkg::PC_W-1:0] fetch_addr_q;
  logic fetch_strobe_q;
  logic int_ack_q;
  logic [1:0] phase_q;
  logic exec_ok;

  function automatic logic is_branch(input pss_pkg::pss_op_t op);
    is_branch = (op == pss_pkg::OP_JUMP) || (op == pss_pkg::OP_CALL) ||
                (op == pss_pkg::OP_RET) || (op == pss_pkg::OP_RETURN_FROM_INTERRUPT);
  endfunction : is_branch

  // reset release through two flip-flops
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  pss_phase_gen u_phase
  (
    .clk(clk),
    .rst_n(rst_n_q),
    .phase(phase),
    .cycle_end(cycle_end)
  );

  pss_ret_stack #(.DEPTH(pss_pkg::DEPTH)) u_stack
  (
    .clk(clk),
    .rst_n(rst_n_q),
    .req(sreq),
    .top(stk_top),
    .full(stk_full),
    .empty(stk_empty)
  );

  assign exec_ok = instr.valid && ir_valid_q;

  // an interrupt is taken only at a cycle boundary with a free stack level
  assign int_take = cycle_end && int_pend_q && !stk_full &&
                    !(exec_ok && is_branch(instr.op)) && !pcl_wr_pend_q;

  // request edge; the copy idles low like the pin, so reset makes no false edge
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      int_req_q <= 1'b0;
    else
      int_req_q <= int_req;
  end

  assign int_rise = int_req && !int_req_q;

  // interrupt request latch; a new request wins over the acknowledge clear
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      int_pend_q <= 1'b0;
    else if (int_rise)
      int_pend_q <= 1'b1;
    else if (int_take)
      int_pend_q <= 1'b0;
  end

  // stack requests, issued at the end of the executing cycle
  always_comb
  begin
    sreq.push = 1'b0;
    sreq.pop = 1'b0;
    sreq.data = pc_q;
    if (int_take)
      sreq.push = 1'b1;
    else if (cycle_end && exec_ok && instr.op == pss_pkg::OP_CALL)
      sreq.push = 1'b1;
    else if (cycle_end && exec_ok &&
             (instr.op == pss_pkg::OP_RET || instr.op == pss_pkg::OP_RETURN_FROM_INTERRUPT))
      sreq.pop = 1'b1;
  end

  // next counter value and whether the prefetched word is thrown away
  always_comb
  begin
    pc_d = pc_q + 10'h001;
    flush_d = 1'b0;
    if (int_take)
    begin
      pc_d = INT_VECTOR;
      flush_d = 1'b1;
    end
    else if (pcl_wr_pend_q)
    begin
      pc_d = {pc_q[pss_pkg::PC_W-1:pss_pkg::OFS_W], pcl_new_q};
      flush_d = 1'b1;
    end
    else if (exec_ok)
      case (instr.op)
        pss_pkg::OP_JUMP, pss_pkg::OP_CALL:
        begin
          pc_d = instr.target;
          flush_d = 1'b1;
        end
        pss_pkg::OP_RET, pss_pkg::OP_RETURN_FROM_INTERRUPT:
        begin
          pc_d = stk_top;
          flush_d = 1'b1;
        end
        pss_pkg::OP_SKIP:
          flush_d = instr.skip_true;
        default: flush_d = 1'b0;
      endcase
  end

  // counter loads at the T4/T1 boundary so T1 fetches the new address
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      pc_q <= pss_pkg::RESET_VECTOR;
    else if (cycle_end)
      pc_q <= pc_d;
  end

  // fetched word moves into the execute slot; flush turns it into a dummy
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ir_q <= 14'h0000;
      ir_valid_q <= 1'b0;
    end
    else if (cycle_end)
    begin
      ir_q <= fetch_word;
      ir_valid_q <= !flush_d;
    end
  end

  // program memory address driven during T1 of each cycle
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      fetch_addr_q <= pss_pkg::RESET_VECTOR;
      fetch_strobe_q <= 1'b0;
    end
    else
    begin
      fetch_addr_q <= cycle_end ? pc_d : pc_q;
      fetch_strobe_q <= cycle_end;
    end
  end

  // software write to the low byte is held until the cycle boundary
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pcl_wr_pend_q <= 1'b0;
      pcl_new_q <= 8'h00;
    end
    else if (reg_wr && reg_addr == pss_pkg::REG_PC_LOW)
    begin
      pcl_wr_pend_q <= 1'b1;
      pcl_new_q <= reg_wdata;
    end
    else if (cycle_end)
      pcl_wr_pend_q <= 1'b0;
  end

  // read port: low byte, status, page bits; stack contents have no address
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      rdata_q <= 8'h00;
    else if (reg_rd)
      case (reg_addr)
        pss_pkg::REG_PC_LOW: rdata_q <= pc_q[pss_pkg::OFS_W-1:0];
        pss_pkg::REG_STATUS: rdata_q <= {4'h0, int_pend_q, stk_empty, stk_full, ir_valid_q};
        pss_pkg::REG_INTVEC: rdata_q <= {6'h00, pc_q[pss_pkg::PC_W-1:pss_pkg::OFS_W]};
        default: rdata_q <= 8'h00;
      endcase
    else
      rdata_q <= 8'h00;
  end

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      int_ack_q <= 1'b0;
      phase_q <= 2'b00;
    end
    else
    begin
      int_ack_q <= int_take;
      phase_q <= cycle_end ? 2'b00 : 2'(phase + 2'b01);
    end
  end

  assign reg_rdata = rdata_q;
  assign fetch_addr = fetch_addr_q;
  assign fetch_strobe = fetch_strobe_q;
  assign exec_word = ir_q;
  assign exec_valid = ir_valid_q;
  assign int_ack = int_ack_q;
  assign phase_out = phase_q;

  // pipeline and counter checks
  pc_hold_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    !cycle_end |=> pc_q == $past(pc_q))
    else $error("counter moved outside cycle boundary");
  phase_rot_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    cycle_end |-> ##4 cycle_end)
    else $error("instruction cycle is not four phases");
  seq_inc_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    cycle_end && !flush_d |=> pc_q == $past(pc_q) + 10'h001)
    else $error("sequential counter step is not one");
  page_keep_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    cycle_end && pcl_wr_pend_q && !int_take |=>
      pc_q[9:8] == $past(pc_q[9:8]) && !ir_valid_q)
    else $error("low byte write left page or no dummy");
  skip_dummy_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    cycle_end && exec_ok && instr.op == pss_pkg::OP_SKIP && instr.skip_true
      && !int_take && !pcl_wr_pend_q |=> !ir_valid_q)
    else $error("true skip did not insert dummy");
  branch_two_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    cycle_end && exec_ok && is_branch(instr.op) && !pcl_wr_pend_q |=>
      !ir_valid_q ##4 (ir_valid_q || $past(int_take) || $past(pcl_wr_pend_q)))
    else $error("branch did not take two cycles");
  full_hold_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    stk_full |-> !int_take)
    else $error("interrupt acknowledged with full stack");
  ret_load_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    sreq.pop && !pcl_wr_pend_q |=> pc_q == $past(stk_top))
    else $error("return did not reload counter");
  reset_vec_a: assert property (@(posedge clk)
    $rose(rst_n_q) |-> pc_q == pss_pkg::RESET_VECTOR && stk_empty)
    else $error("reset did not clear counter and stack");

  // interrupt entry, stack and register port checks
  int_latch_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    int_rise |=> int_pend_q)
    else $error("interrupt request not latched");
  ack_entry_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    int_take |=> int_ack_q && fetch_strobe_q && fetch_addr_q == INT_VECTOR && !ir_valid_q)
    else $error("interrupt entry not at vector");
  ack_push_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    int_take |-> sreq.push && sreq.data == pc_q)
    else $error("interrupt did not save counter");
  call_full_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    cycle_end && exec_ok && instr.op == pss_pkg::OP_CALL && !int_take |-> sreq.push)
    else $error("call not pushed");
  fetch_t1_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    fetch_strobe_q |-> phase == pss_pkg::PH_T1)
    else $error("fetch outside first phase");
  wrap_full_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    stk_full && sreq.push |=> stk_full)
    else $error("overflow changed stack fill");
  exec_hold_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    !cycle_end |=> $stable(ir_q) && $stable(ir_valid_q))
    else $error("execute slot moved inside a cycle");
  rdata_idle_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    !reg_rd |=> rdata_q == 8'h00)
    else $error("read data without a read");
  pcl_read_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    reg_rd && reg_addr == pss_pkg::REG_PC_LOW |=> rdata_q == $past(pc_q[7:0]))
    else $error("low byte read mismatch");
  ret_pop_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    cycle_end && exec_ok &&
      (instr.op == pss_pkg::OP_RET || instr.op == pss_pkg::OP_RETURN_FROM_INTERRUPT) |-> sreq.pop)
    else $error("return did not pop");
endmodule : pss_sequencer
`default_nettype wire

// *** pss_prog_model.sv ***
/*
  Partner model: program memory, instruction decoder and interrupt source.
  Assumes the sequencer samples fetch_word and instr at the end of T4.
*/
`timescale 1ns/10ps
`default_nettype none
module pss_prog_model
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // program memory
  input wire logic [pss_pkg::PC_W-1:0] fetch_addr,
  output logic [13:0] fetch_word,
  // decoder
  input wire logic [13:0] exec_word,
  input wire logic exec_valid,
  output var pss_pkg::pss_instr_t instr,
  // interrupt source
  input wire logic raise,
  input wire logic int_ack,
  output logic int_req
);
  logic [13:0] mem [1024];

  // word layout: op, skip condition, target
  initial
  begin
    foreach (mem[i]) mem[i] = 14'h0000;
    mem[10'h001] = {pss_pkg::OP_CALL, 1'b0, 10'h010};
    mem[10'h002] = {pss_pkg::OP_SKIP, 1'b1, 10'h000};
    mem[10'h004] = {pss_pkg::OP_JUMP, 1'b0, 10'h300};
    mem[10'h010] = {pss_pkg::OP_CALL, 1'b0, 10'h020};
    mem[10'h011] = {pss_pkg::OP_JUMP, 1'b0, 10'h002};
    mem[10'h020] = {pss_pkg::OP_CALL, 1'b0, 10'h030};
    mem[10'h021] = {pss_pkg::OP_RET, 1'b0, 10'h000};
    mem[10'h030] = {pss_pkg::OP_CALL, 1'b0, 10'h040};
    mem[10'h031] = {pss_pkg::OP_RETURN_FROM_INTERRUPT, 1'b0, 10'h000};
    mem[10'h041] = {pss_pkg::OP_CALL, 1'b0, 10'h050};
    mem[10'h042] = {pss_pkg::OP_RET, 1'b0, 10'h000};
    mem[10'h050] = {pss_pkg::OP_RET, 1'b0, 10'h000};
  end

  assign fetch_word = mem[fetch_addr];

  always_comb
  begin
    instr.valid = exec_valid;
    instr.op = pss_pkg::pss_op_t'(exec_word[13:11]);
    instr.target = exec_word[9:0];
    instr.skip_true = exec_word[10];
  end

  // request stays up until acknowledged
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      int_req <= 1'b0;
    else if (raise)
      int_req <= 1'b1;
    else if (int_ack)
      int_req <= 1'b0;
  end
endmodule : pss_prog_model
`default_nettype wire

// *** program_sequencer_stack_bench.sv ***
/*
  Self-checking bench for the program sequencer: register tasks, fetch trace,
  stack overflow and interrupt hold-off.
  Assumes pss_pkg, pss_sequencer and pss_prog_model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module program_sequencer_stack_bench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [pss_pkg::PC_W-1:0] fetch_addr;
  logic fetch_strobe;
  logic [13:0] fetch_word;
  pss_pkg::pss_instr_t instr;
  logic [13:0] exec_word;
  logic exec_valid;
  logic [1:0] phase_out;
  logic int_req;
  logic int_ack;
  logic raise = 1'b0;
  logic [7:0] rv;
  int n;
  int err_count = 0;
  int comparisons = 0;
  int ack_cnt = 0;
  time last = 0;
  // {check valid, exec_valid, fetch address} per fetch
  logic [11:0] trace [28] = '{12'h000, 12'hC01, 12'hC02, 12'h810, 12'hC11, 12'h820,
    12'hC21, 12'h830, 12'hC31, 12'h840, 12'hC41, 12'hC42, 12'h850, 12'hC51, 12'h842,
    12'hC43, 12'h831, 12'hC32, 12'h821, 12'hC22, 12'h811, 12'hC12, 12'h802, 12'hC03,
    12'h804, 12'hC05, 12'hB00, 12'hF01};

  always #12.5 clk = ~clk;

  pss_sequencer i_dut
  (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fetch_addr(fetch_addr),
    .fetch_strobe(fetch_strobe), .fetch_word(fetch_word), .instr(instr),
    .exec_word(exec_word), .exec_valid(exec_valid), .phase_out(phase_out),
    .int_req(int_req), .int_ack(int_ack)
  );

  pss_prog_model i_mem
  (
    .clk(clk), .rst_n(nrst), .fetch_addr(fetch_addr), .fetch_word(fetch_word),
    .exec_word(exec_word), .exec_valid(exec_valid), .instr(instr),
    .raise(raise), .int_ack(int_ack), .int_req(int_req)
  );

  always @(negedge clk)
    if (int_ack === 1'b1)
      ack_cnt++;

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("FAIL at %0t ns: %s", $time, msg);
    end
  endtask : chk

  task automatic do_reset();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    // let the internal reset copy release before looking at the reset vector
    repeat (2) @(posedge clk);
    last = 0;
  endtask : do_reset

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd

  // with e[11] set, waits for the next fetch strobe and checks dummy flag and spacing; always checks address, phase
  task automatic fetch(input logic [11:0] e);
    int k;
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end
    while (e[11] && fetch_strobe !== 1'b1 && k < 40);
    chk(fetch_addr === e[9:0] && phase_out === 2'h0, "fetch address");
    if (e[11])
    begin
      chk(exec_valid === e[10], "dummy cycle flag");
      chk($time - last == 100, "instruction cycle length");
    end
    last = $time;
  endtask : fetch

  initial
  begin
    #100000;
    err_count++;
    close_out();
  end

  initial
  begin
    do_reset();
    fetch(trace[0]);
    rd(2'h1, rv);
    chk(rv[3:1] === 3'b010, "status after reset");
    for (int i = 1; i < 28; i++)
      fetch(trace[i]);
    wr(2'h0, 8'h80);
    fetch(12'hB80);
    rd(2'h0, rv);
    chk(rv === 8'h80, "low byte readback");
    wr(2'h2, 8'h00);
    rd(2'h2, rv);
    chk(rv === 8'h03, "page bits kept");
    rd(2'h3, rv);
    chk(rv === 8'h00, "unmapped read");
    do_reset();
    for (int i = 0; i < 10; i++)
      fetch(trace[i]);
    @(posedge clk);
    raise <= 1'b1;
    @(posedge clk);
    raise <= 1'b0;
    fetch(trace[10]);
    rd(2'h1, rv);
    chk(rv[3:1] === 3'b101, "request held while full");
    for (int i = 11; i < 15; i++)
      fetch(trace[i]);
    chk(ack_cnt == 0, "acknowledge while full");
    n = 0;
    while (int_ack !== 1'b1 && n < 16)
    begin
      @(negedge clk);
      n++;
    end
    chk(int_ack === 1'b1 && fetch_strobe === 1'b1 && fetch_addr === pss_pkg::INT_VECTOR_DEF
      && exec_valid === 1'b0 && exec_word === {pss_pkg::OP_RET, 1'b0, 10'h000},
      "interrupt entry");
    close_out();
  end
endmodule : program_sequencer_stack_bench
`default_nettype wire
